// *** sim/reset_sources_and_watchdog_tb.sv ***
// Self-checking bench for the reset sequencer and watchdog
module reset_sources_and_watchdog_tb;
  import rst_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MON = 20;
  logic        clk = 0;
  logic        reset = 1;
  logic [1:0]  address = 0;
  logic        read = 0;
  logic        write = 0;
  logic [31:0] writedata = 0;
  logic [31:0] readdata;
  logic        waitrequest, rst_pin_in, rst_pin_out, rst_pin_oe, supply_ok, osc_stable;
  logic        core_reset, osc_select_lowest, fetch_enable, port_latch_load, adc_conv_start_n;
  logic        supply_up = 0;
  logic        ext_low = 0;
  logic        mon_en = 1;
  logic        cnv_in = 1;
  logic        cmp_low = 0;
  logic        clk_miss = 0;
  logic [15:0] pc_start_addr;
  logic [7:0]  port_latch_init;
  logic [7:0]  v;
  logic [7:0]  en[3] = '{8'h06, 8'h22, 8'h42};
  logic [7:0]  fl[3] = '{8'h04, 8'h20, 8'h40};
  logic [31:0] exp_q[$];
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;

  always #25 clk = ~clk;

  reset_sources_and_watchdog #(.MON_TIMEOUT_CYC(MON), .WDT_W(21)) DUT (
    .clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest, .supply_ok,
    .supply_monitor_enable_pin(mon_en), .rst_pin_in, .rst_pin_out, .rst_pin_oe,
    .conversion_start_input(cnv_in), .comparator_low(cmp_low), .clock_missing(clk_miss),
    .osc_stable, .core_reset, .osc_select_lowest, .fetch_enable, .pc_start_addr,
    .port_latch_load, .port_latch_init, .adc_conv_start_n);
  rst_partner far (.clk, .rst_pin_oe, .rst_pin_out, .ext_pull_low(ext_low), .supply_up,
    .rst_pin_in, .supply_ok, .osc_stable);

  task automatic wrap_up();
    if (exp_q.size() != 0) num_errors++;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic bus(input logic [1:0] a, input logic rd_n_wr, input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    read      <= rd_n_wr;
    write     <= !rd_n_wr;
    writedata <= {24'h0, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(a, 1'b0, d);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(a, 1'b1, 8'h00);
  endtask : rd

  // Waits for a {core_reset, rst_pin_oe} pattern; a miss is an error
  task automatic wait_out(input logic [1:0] pat, input int lim, output int k);
    k = 0;
    while ({core_reset, rst_pin_oe} !== pat && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, k < lim}, 32'h1, "output pattern");
  endtask : wait_out

  task automatic set_src(input int i, input logic on);
    case (i)
      0: clk_miss <= on;
      1: cmp_low <= on;
      default: cnv_in <= !on;
    endcase
  endtask : set_src

  // Read results are matched against the oldest expectation
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
    if (read && !waitrequest) chk(readdata, exp_q.pop_front(), "read data");
  end

  initial begin
    void'($urandom(87165));
    repeat (5) @(posedge clk);
    chk({26'h0, core_reset, rst_pin_oe, rst_pin_out, port_latch_load, osc_select_lowest, fetch_enable},
        32'h36, "in reset");
    chk({8'h0, pc_start_addr, port_latch_init}, 32'h0000ff, "start state");
    reset     <= 1'b0;
    supply_up <= 1'b1;
    wait_out(2'b10, MON + 10, n);
    chk({31'h0, n >= MON}, 32'h1, "pin held low");
    wait_out(2'b00, 30, n);
    chk({31'h0, n >= 12}, 32'h1, "stretch");
    chk({31'h0, fetch_enable}, 32'h1, "fetch");
    rd(2'h1, 8'h02);
    rd(2'h0, 8'h17);
    rd(2'h2, 8'h00);
    // Interval kept long here so the watchdog cannot trip mid-test
    v = 8'($urandom_range(6, 3));
    wr(2'h0, v);
    rd(2'h0, 8'h10 | v);
    wr(2'h0, 8'h80 | (v + 8'h1));
    rd(2'h0, 8'h10 | v);
    wr(2'h0, 8'hde);
    repeat (3) @(posedge clk);
    wr(2'h0, 8'had);
    rd(2'h0, 8'h10 | v);
    wr(2'h0, 8'hde);
    wr(2'h0, 8'had);
    rd(2'h0, v);
    wr(2'h0, 8'h00);
    repeat (150) @(posedge clk);
    chk({31'h0, core_reset}, 32'h0, "disabled");
    wr(2'h0, 8'hff);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'ha5);
    rd(2'h0, 8'h10);
    wr(2'h0, 8'hde);
    wr(2'h0, 8'had);
    rd(2'h0, 8'h10);
    repeat (3) begin
      repeat (40) @(posedge clk);
      wr(2'h0, 8'ha5);
    end
    chk({31'h0, core_reset}, 32'h0, "kept alive");
    wait_out(2'b10, 100, n);
    chk({31'h0, n >= 62 && n <= 68}, 32'h1, "timeout");
    wait_out(2'b00, 40, n);
    rd(2'h1, 8'h08);
    rd(2'h0, 8'h17);
    for (int i = 0; i < 3; i++) begin
      set_src(i, 1'b1);
      repeat (6) @(posedge clk);
      chk({31'h0, core_reset}, 32'h0, "source off");
      if (i == 2) chk({31'h0, adc_conv_start_n}, 32'h0, "conv passes");
      set_src(i, 1'b0);
      repeat (4) @(posedge clk);
      // Each source is settled off before its reset is armed
      wr(2'h1, en[i]);
      set_src(i, 1'b1);
      repeat (2) @(posedge clk);
      chk({31'h0, adc_conv_start_n}, 32'h1, "conv blocked");
      wait_out(2'b10, 10, n);
      set_src(i, 1'b0);
      wait_out(2'b00, 40, n);
      rd(2'h1, fl[i]);
    end
    ext_low <= 1'b1;
    wait_out(2'b10, 10, n);
    repeat (5) @(posedge clk);
    ext_low <= 1'b0;
    wait_out(2'b00, 30, n);
    chk({31'h0, n >= 12}, 32'h1, "pin stretch");
    rd(2'h1, 8'h01);
    supply_up <= 1'b0;
    wait_out(2'b11, 10, n);
    supply_up <= 1'b1;
    wait_out(2'b10, MON + 10, n);
    wait_out(2'b00, 30, n);
    rd(2'h1, 8'h02);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule : reset_sources_and_watchdog_tb

// *** sim/rst_partner.sv ***
// Far-side model: reset pin wiring, supply and oscillator start-up
module rst_partner (
  input  wire logic clk,
  input  wire logic rst_pin_oe,
  input  wire logic rst_pin_out,
  input  wire logic ext_pull_low,
  input  wire logic supply_up,
  output logic      rst_pin_in,
  output logic      supply_ok,
  output logic      osc_stable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] warm_q = 4'h0;
  // Pin has a pull-up, so released means high
  assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | ext_pull_low);
  assign supply_ok  = supply_up;
  // Oscillator needs a few clocks after the supply returns
  always @(posedge clk) begin
    if (!supply_up) warm_q <= 4'h0;
    else if (warm_q != 4'hf) warm_q <= warm_q + 4'h1;
  end
  assign osc_stable = (warm_q == 4'hf);
endmodule : rst_partner

// *** src/reset_sources_and_watchdog.sv ***
// Reset source merge, reset sequencer, source flags and system watchdog
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`include "rst_map.svh"
module reset_sources_and_watchdog
  import rst_pkg::*;
#(
  parameter int unsigned MON_TIMEOUT_CYC = `MON_TIMEOUT_MS * (`CLK_HZ / 1000),
  parameter int unsigned WDT_W           = 21
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        supply_ok,
  input  wire logic        supply_monitor_enable_pin,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe,
  input  wire logic        conversion_start_input,
  input  wire logic        comparator_low,
  input  wire logic        clock_missing,
  input  wire logic        osc_stable,
  output logic             core_reset,
  output logic             osc_select_lowest,
  output logic             fetch_enable,
  output logic      [15:0] pc_start_addr,
  output logic             port_latch_load,
  output logic      [7:0]  port_latch_init,
  output logic             adc_conv_start_n
);
  localparam int unsigned MW = $clog2(MON_TIMEOUT_CYC + 1);

  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic       supply_ok_s;
  logic       mon_en_s;
  logic       pin_s;
  logic       cnv_s;
  logic       cmp_low_s;
  logic       mcd_s;
  logic       osc_s;

  state_t     state_q;
  cause_t     cause_q;
  logic [MW-1:0] mon_cnt_q;
  logic [3:0] hold_cnt_q;
  logic       run;
  logic       sys_rst;
  logic       mon_low;

  logic       monitor_sel_q;
  logic       mcd_en_q;
  logic       cmp_en_q;
  logic       cnv_en_q;
  logic [7:0] flags_q;

  logic       ack_q;
  logic       wr_acc;
  logic [7:0] wdata;
  logic [7:0] rd_mux;
  logic [31:0] readdata_q;

  logic             wdt_en_q;
  logic             wdt_lock_q;
  logic [2:0]       wdt_ivl_q;
  logic [2:0]       de_cnt_q;
  logic [WDT_W-1:0] wdt_cnt_q;
  logic [WDT_W-1:0] wdt_limit;
  logic             wdt_ovf;
  logic             wdt_wr;
  logic             src_pin;
  logic             src_mcd;
  logic             src_cmp;
  logic             src_cnv;

  // Pins are asynchronous; the first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= `SYNC_RST;
      sync_q <= `SYNC_RST;
    end else begin
      meta_q <= {osc_stable, clock_missing, comparator_low, conversion_start_input,
                 rst_pin_in, supply_monitor_enable_pin, supply_ok};
      sync_q <= meta_q;
    end
  end

  assign supply_ok_s = sync_q[0];
  assign mon_en_s    = sync_q[1];
  assign pin_s       = sync_q[2];
  assign cnv_s       = sync_q[3];
  assign cmp_low_s   = sync_q[4];
  assign mcd_s       = sync_q[5];
  assign osc_s       = sync_q[6];

  assign run     = (state_q == S_RUN);
  assign sys_rst = reset | ~run;
  assign mon_low = mon_en_s & monitor_sel_q & ~supply_ok_s;

  assign src_pin = ~pin_s;
  assign src_mcd = mcd_en_q & mcd_s;
  assign src_cmp = cmp_en_q & cmp_low_s;
  assign src_cnv = cnv_en_q & ~cnv_s;

  // Reset sequencer; supply loss overrides every other state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= S_SUPPLY;
    end else begin
      case (state_q)
        S_SUPPLY: begin
          if (!mon_low) begin
            state_q <= S_MONTO;
          end
        end
        S_MONTO: begin
          if (mon_low) begin
            state_q <= S_SUPPLY;
          end else if (mon_cnt_q == MW'(MON_TIMEOUT_CYC - 1)) begin
            state_q <= S_HOLD;
          end
        end
        S_HOLD: begin
          if (mon_low) begin
            state_q <= S_SUPPLY;
          end else if (pin_s) begin
            state_q <= S_STRETCH;
          end
        end
        S_STRETCH: begin
          if (mon_low) begin
            state_q <= S_SUPPLY;
          end else if (!pin_s) begin
            state_q <= S_HOLD;
          end else if (hold_cnt_q == `PIN_HOLD_CYC - 4'h1) begin
            state_q <= S_RUN;
          end
        end
        S_RUN: begin
          if (mon_low) begin
            state_q <= S_SUPPLY;
          end else if (src_pin | src_mcd | wdt_ovf | src_cmp | src_cnv) begin
            state_q <= S_HOLD;
          end
        end
        default: begin
          state_q <= S_SUPPLY;
        end
      endcase
    end
  end

  // Cause is latched on entry to reset, with a fixed priority
  always_ff @(posedge clk) begin
    if (reset) begin
      cause_q <= C_POWER;
    end else if (mon_low) begin
      cause_q <= C_POWER;
    end else if (run) begin
      if (src_pin) begin
        cause_q <= C_PIN;
      end else if (src_mcd) begin
        cause_q <= C_MCD;
      end else if (wdt_ovf) begin
        cause_q <= C_WDT;
      end else if (src_cmp) begin
        cause_q <= C_CMP;
      end else if (src_cnv) begin
        cause_q <= C_CNV;
      end
    end
  end

  // The 100 ms count is long, so simulations shorten it by parameter
  always_ff @(posedge clk) begin
    if (reset || state_q != S_MONTO) begin
      mon_cnt_q <= '0;
    end else begin
      mon_cnt_q <= mon_cnt_q + MW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q != S_STRETCH) begin
      hold_cnt_q <= 4'h0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 4'h1;
    end
  end

  // Flags change only when reset ends, so they name the latest cause
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_q <= 8'h00;
    end else if (state_q == S_STRETCH && pin_s && !mon_low &&
                 hold_cnt_q == `PIN_HOLD_CYC - 4'h1) begin
      flags_q                <= 8'h00;
      flags_q[`FLAG_POR_BIT] <= (cause_q == C_POWER);
      flags_q[`FLAG_PIN_BIT] <= (cause_q == C_PIN);
      flags_q[`FLAG_MCD_BIT] <= (cause_q == C_MCD);
      flags_q[`FLAG_WDT_BIT] <= (cause_q == C_WDT);
      flags_q[`FLAG_CMP_BIT] <= (cause_q == C_CMP);
      flags_q[`FLAG_CNV_BIT] <= (cause_q == C_CNV);
    end
  end

  // Avalon slave: one wait cycle on every access, unmapped reads return zero
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_acc      = write & ack_q & run;
  assign wdata       = writedata[7:0];
  assign readdata    = readdata_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    case (address)
      `REG_WDT_CTRL: begin
        rd_mux                  = {5'h00, wdt_ivl_q};
        rd_mux[`WDT_STATUS_BIT] = wdt_en_q;
      end
      `REG_RST_SRC: begin
        rd_mux = flags_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // Source enables; they return to reset values in reset, while the source flags keep theirs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      monitor_sel_q <= 1'b1;
      mcd_en_q      <= 1'b0;
      cmp_en_q      <= 1'b0;
      cnv_en_q      <= 1'b0;
    end else if (wr_acc && address == `REG_RST_SRC) begin
      monitor_sel_q <= wdata[`FLAG_POR_BIT];
      mcd_en_q      <= wdata[`FLAG_MCD_BIT];
      cmp_en_q      <= wdata[`FLAG_CMP_BIT];
      cnv_en_q      <= wdata[`FLAG_CNV_BIT];
    end
  end

  // Watchdog
  assign wdt_wr    = wr_acc && address == `REG_WDT_CTRL;
  assign wdt_limit = WDT_W'(1) << (5'd6 + {1'b0, wdt_ivl_q, 1'b0});
  assign wdt_ovf   = wdt_en_q && wdt_cnt_q == wdt_limit - WDT_W'(1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_en_q   <= 1'b1;
      wdt_cnt_q  <= '0;
      wdt_lock_q <= 1'b0;
      wdt_ivl_q  <= `WDT_INTERVAL_RST;
      de_cnt_q   <= 3'h0;
    end else begin
      de_cnt_q <= (de_cnt_q != 3'h0) ? de_cnt_q - 3'h1 : 3'h0;
      if (wdt_en_q) begin
        wdt_cnt_q <= wdt_cnt_q + WDT_W'(1);
      end
      if (wdt_wr) begin
        if (wdata == `WDT_RESTART) begin
          wdt_en_q  <= 1'b1;
          wdt_cnt_q <= '0;
        end else if (wdata == `WDT_DIS_FIRST) begin
          de_cnt_q <= `WDT_DIS_WINDOW;
        end else if (wdata == `WDT_DIS_SECOND) begin
          if (de_cnt_q != 3'h0 && !wdt_lock_q) begin
            wdt_en_q <= 1'b0;
          end
        end else if (wdata == `WDT_LOCKOUT) begin
          wdt_lock_q <= 1'b1;
        end else if (!wdata[`WDT_WR_GUARD_BIT]) begin
          wdt_ivl_q <= wdata[2:0];
        end
      end
    end
  end

  // Data memory has no clear path from here; only registers reset
  assign core_reset        = ~run;
  assign port_latch_load   = ~run;
  assign port_latch_init   = `PORT_LATCH_RST;
  assign pc_start_addr     = `PC_RST_ADDR;
  assign osc_select_lowest = ~run;
  assign fetch_enable      = run & osc_s;
  // Only the supply monitor pulls the pin; other sources leave it alone
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe  = (state_q == S_SUPPLY) | (state_q == S_MONTO);
  // Conversion starts are blocked while the input serves as a reset
  assign adc_conv_start_n = cnv_en_q | cnv_s;

  property p_src_resets;
    @(posedge clk) disable iff (reset)
      (run && !mon_low && (wdt_ovf || src_cmp || src_cnv || src_mcd)) |=> core_reset && !rst_pin_oe;
  endproperty
  a_src_resets: assert property (p_src_resets) else $error("source did not reset");

  property p_latch_ones;
    @(posedge clk) disable iff (reset)
      core_reset |-> port_latch_load && port_latch_init == 8'hff;
  endproperty
  a_latch_ones: assert property (p_latch_ones) else $error("latches not all ones");

  property p_pin_low_timeout;
    @(posedge clk) disable iff (reset)
      (state_q == S_SUPPLY && !mon_low) |=> rst_pin_oe && core_reset;
  endproperty
  a_pin_low_timeout: assert property (p_pin_low_timeout) else $error("pin released early");

  property p_pin_hold;
    @(posedge clk) disable iff (reset)
      (state_q == S_HOLD && pin_s && !mon_low) |=> core_reset [*8];
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin hold too short");

  property p_por_flag;
    @(posedge clk) disable iff (reset)
      ($rose(run) && cause_q != C_POWER) |-> !flags_q[`FLAG_POR_BIT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power flag not cleared");

  property p_restart;
    @(posedge clk) disable iff (reset)
      (wdt_wr && wdata == 8'ha5) |=> wdt_en_q && wdt_cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed");

  property p_late_disable;
    @(posedge clk) disable iff (reset)
      (wdt_wr && wdata == 8'had && (de_cnt_q == 3'h0 || wdt_lock_q) && wdt_en_q && !wdt_ovf) |=> wdt_en_q;
  endproperty
  a_late_disable: assert property (p_late_disable) else $error("bad disable taken");

  property p_lockout;
    @(posedge clk) disable iff (reset)
      (wdt_wr && wdata == 8'hff && !wdt_ovf) |=> wdt_lock_q && wdt_en_q == $past(wdt_en_q);
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout changed state");

  property p_after_reset;
    @(posedge clk) disable iff (reset)
      $rose(run) |-> wdt_en_q && wdt_ivl_q == 3'h7 && wdt_cnt_q == '0;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("watchdog not at default");

  property p_interval;
    @(posedge clk) disable iff (reset)
      (wdt_wr && !wdata[7] && !wdt_ovf) |=> wdt_ivl_q == $past(wdata[2:0]);
  endproperty
  a_interval: assert property (p_interval) else $error("interval not written");

endmodule : reset_sources_and_watchdog

// *** src/rst_map.svh ***
// Register offsets, field positions, codes and timing counts of the reset block
// Operation
// - In reset: halt core, reset registers, disable interrupts
// - Reset never touches internal data memory
// - Port latches go to all ones
// - Exit: PC zero, slowest oscillator, fetch when stable
// - Power-up: hold until supply good, pin low 100 ms
// - Monitor active by enable pin and power-on select bit
// - Power-on sets its flag; other resets clear it
// - Supply drop drives pin low, exits like power-on
// - Pin low resets; hold 12 clocks after release
// - Enabled missing-clock reset sets its flag, pin untouched
// - Enabled comparator low resets, sets flag, pin untouched
// - Enabled conversion-start low resets, no longer starts conversions
// - 21-bit watchdog overflow resets, pin untouched
// - Restart code enables watchdog and clears count
// - After reset watchdog runs with longest interval
// - Disable needs two codes within 4 clocks
// - Lockout code blocks disable until reset
// - Timeout four to three-plus-interval; bit 7 guards write
`ifndef RST_MAP_SVH
`define RST_MAP_SVH
`define CLK_HZ           20000000
`define MON_TIMEOUT_MS   100
`define PIN_HOLD_CYC     4'hc
`define WDT_DIS_WINDOW   3'h4
`define REG_WDT_CTRL     2'h0
`define REG_RST_SRC      2'h1
`define WDT_RESTART      8'ha5
`define WDT_DIS_FIRST    8'hde
`define WDT_DIS_SECOND   8'had
`define WDT_LOCKOUT      8'hff
`define WDT_INTERVAL_RST 3'h7
`define WDT_WR_GUARD_BIT 7
`define WDT_STATUS_BIT   4
`define FLAG_PIN_BIT     0
`define FLAG_POR_BIT     1
`define FLAG_MCD_BIT     2
`define FLAG_WDT_BIT     3
`define FLAG_CMP_BIT     5
`define FLAG_CNV_BIT     6
`define PORT_LATCH_RST   8'hff
`define PC_RST_ADDR      16'h0000
// Idle levels after reset: monitor on, pin and conversion input high, so no false edges
`define SYNC_RST         7'h0e
`endif

// *** src/rst_pkg.sv ***
// Types shared by the reset and watchdog block
package rst_pkg;
  typedef enum logic [4:0] {
    S_SUPPLY  = 5'h01,
    S_MONTO   = 5'h02,
    S_HOLD    = 5'h04,
    S_STRETCH = 5'h08,
    S_RUN     = 5'h10
  } state_t;
  typedef enum logic [5:0] {
    C_POWER = 6'h01,
    C_PIN   = 6'h02,
    C_MCD   = 6'h04,
    C_WDT   = 6'h08,
    C_CMP   = 6'h10,
    C_CNV   = 6'h20
  } cause_t;
endpackage : rst_pkg
